// file: inc/prts_pkg.sv
package prts_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int FERR_W = 20;
	localparam int BUF_AW = 8;
	localparam int CLK_PERIOD_NS = 40;

	// timeout step sizes, selected by the low two bits of the step-size register
	localparam int STEP0_NS = 15625;
	localparam int STEP1_NS = 62500;
	localparam int STEP2_NS = 1000000;
	localparam int STEP3_NS = 4000000;
	localparam int STEP0_CYC = STEP0_NS / CLK_PERIOD_NS;
	localparam int STEP1_CYC = STEP1_NS / CLK_PERIOD_NS;
	localparam int STEP2_CYC_DEF = STEP2_NS / CLK_PERIOD_NS;
	localparam int STEP3_CYC_DEF = STEP3_NS / CLK_PERIOD_NS;

	localparam logic [15:0] COUNT_SINGLE = 16'h0000;
	localparam logic [15:0] COUNT_CONT = 16'hffff;

	localparam logic [ADDR_W-1:0] OFS_STEP_SIZE = 12'h900;
	localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 12'h901;
	localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 12'h902;
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 12'h903;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h904;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h905;
	localparam logic [ADDR_W-1:0] OFS_ROUTE0 = 12'h906;
	localparam logic [ADDR_W-1:0] OFS_ROUTE1 = 12'h907;
	localparam logic [ADDR_W-1:0] OFS_ROUTE2 = 12'h908;
	localparam logic [ADDR_W-1:0] OFS_SNR = 12'h909;
	localparam logic [ADDR_W-1:0] OFS_RX_LEN = 12'h90a;
	localparam logic [ADDR_W-1:0] OFS_RX_FIRST = 12'h90b;
	localparam logic [ADDR_W-1:0] OFS_MODE = 12'h90c;
	localparam logic [ADDR_W-1:0] OFS_TX_BASE = 12'h90d;
	localparam logic [ADDR_W-1:0] OFS_RX_BASE = 12'h90e;
	localparam logic [ADDR_W-1:0] OFS_IQ_INV = 12'h90f;
	localparam logic [ADDR_W-1:0] OFS_BUF_PTR = 12'h910;
	localparam logic [ADDR_W-1:0] OFS_BUF_DATA = 12'h911;
	localparam logic [ADDR_W-1:0] OFS_FERR_HIGH = 12'h954;
	localparam logic [ADDR_W-1:0] OFS_FERR_MID = 12'h955;
	localparam logic [ADDR_W-1:0] OFS_FERR_LOW = 12'h956;

	localparam logic [DATA_W-1:0] OP_STANDBY = 8'h00;
	localparam logic [DATA_W-1:0] OP_START_TX = 8'h01;
	localparam logic [DATA_W-1:0] OP_START_RX = 8'h02;

	localparam int FLG_TX_DONE = 0;
	localparam int FLG_RX_DONE = 1;
	localparam int FLG_PREAMBLE = 2;
	localparam int FLG_SYNC = 3;
	localparam int FLG_HDR_OK = 4;
	localparam int FLG_HDR_FAIL = 5;
	localparam int FLG_CRC_FAIL = 6;
	localparam int FLG_TIMEOUT = 7;

	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [FERR_W-1:0] RST_FERR = 20'h00000;

	typedef enum logic [2:0] {
		MODE_STANDBY = 3'b001,
		MODE_TX = 3'b010,
		MODE_RX = 3'b100
	} prts_mode_t;

	typedef struct packed {
		prts_mode_t mode;
		logic rx_cont;
		logic timer_run;
		logic [16:0] presc;
		logic [15:0] steps;
		logic [7:0] step_size;
		logic [7:0] count_hi;
		logic [7:0] count_lo;
		logic [7:0] flags;
		logic [2:0][7:0] route;
		logic [7:0] snr;
		logic [7:0] rx_len;
		logic [7:0] rx_first;
		logic [7:0] rx_wr;
		logic [7:0] tx_base;
		logic [7:0] rx_base;
		logic [7:0] tx_rd;
		logic [7:0] tx_byte;
		logic iq_inv;
		logic [7:0] buf_ptr;
		logic [19:0] ferr;
		logic [7:0] rdata;
	} prts_state_t;
endpackage

// file: core/prts_sequencer.sv
`timescale 1ns/100ps
// How it works
// - end of transmission raises transmit-complete flag and leaves rc standby.
// - expired armed timeout raises timeout flag and returns to rc standby.
// - start commands take step size and 16-bit count; nonzero count arms timeout, except all ones on receive.
// - after transmit done or transmit timeout, go to standby without commands.
// - clear-flags write clears flags under ones in mask, keeps the rest.
// - receive-complete flag rises on any detected packet, valid or not.
// - preamble-detected flag rises when a valid preamble is seen.
// - header-ok flag on valid header, header-fail flag on bad header.
// - sync-match flag rises when sync word is detected.
// - checksum-fail flag rises when received checksum mismatches.
// - receive timeout raises timeout flag when no packet detected in time.
// - receive count zero: single reception, no timeout, standby after packet.
// - receive count all ones: continuous until host sends another mode command.
// - continuous reception reports every packet and keeps searching.
// - other counts arm timer; standby at timer end or packet received.
// - packet detection under armed receive timeout stops the timer.
// - packet snr is two's complement, quarter-dB units.
// - each event pin is OR of routed flags, low once they clear.
// - receive buffer status gives last length and first-byte position.
// - signed 20-bit frequency error across three bytes, msb at lowest address.
// - frequency error sign flips when receiver iq inversion is selected.
// - buffer write stores first byte at the given offset.
module prts_sequencer #(
	parameter int STEP2_CYC = prts_pkg::STEP2_CYC_DEF,
	parameter int STEP3_CYC = prts_pkg::STEP3_CYC_DEF
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [prts_pkg::ADDR_W-1:0] addr_i,
	input wire logic [prts_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [prts_pkg::DATA_W-1:0] rdata_o,
	input wire logic tx_end_i,
	input wire logic tx_byte_req_i,
	output logic [7:0] tx_byte_o,
	input wire logic preamble_i,
	input wire logic sync_i,
	input wire logic header_ok_i,
	input wire logic header_fail_i,
	input wire logic pkt_detect_i,
	input wire logic rx_byte_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_done_i,
	input wire logic crc_fail_i,
	input wire logic [7:0] snr_i,
	input wire logic ferr_valid_i,
	input wire logic [prts_pkg::FERR_W-1:0] ferr_i,
	output logic tx_active_o,
	output logic rx_active_o,
	output logic standby_o,
	output logic [2:0] dio_o
);
	import prts_pkg::*;

	prts_state_t st_q;
	prts_state_t st_d;
	logic [7:0] mem_q [0:(1<<BUF_AW)-1];
	logic mem_we;
	logic [BUF_AW-1:0] mem_wa;
	logic [7:0] mem_wd;
	logic [7:0] set_ev;
	logic [15:0] count;

	function automatic logic [16:0] step_cycles(input logic [7:0] sz);
		logic [16:0] c;
		c = 17'(STEP0_CYC);
		unique case (sz[1:0])
			2'd0: c = 17'(STEP0_CYC);
			2'd1: c = 17'(STEP1_CYC);
			2'd2: c = 17'(STEP2_CYC);
			2'd3: c = 17'(STEP3_CYC);
		endcase
		return c;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	assign count = {st_q.count_hi, st_q.count_lo};

	always_comb begin
		st_d = st_q;
		mem_we = 1'b0;
		mem_wa = st_q.buf_ptr;
		mem_wd = wdata_i;
		set_ev = 8'h00;
		st_d.rdata = RST_BYTE;

		// events only count in the mode they belong to
		set_ev[FLG_TX_DONE] = st_q.mode == MODE_TX && tx_end_i;
		set_ev[FLG_RX_DONE] = st_q.mode == MODE_RX && rx_done_i;
		set_ev[FLG_PREAMBLE] = st_q.mode == MODE_RX && preamble_i;
		set_ev[FLG_SYNC] = st_q.mode == MODE_RX && sync_i;
		set_ev[FLG_HDR_OK] = st_q.mode == MODE_RX && header_ok_i;
		set_ev[FLG_HDR_FAIL] = st_q.mode == MODE_RX && header_fail_i;
		set_ev[FLG_CRC_FAIL] = st_q.mode == MODE_RX && crc_fail_i;

		// timer: count of steps, each step a prescaled number of cycles
		if (st_q.timer_run) begin
			if (st_q.presc == 17'd0) begin
				st_d.presc = step_cycles(st_q.step_size) - 17'd1;
				st_d.steps = st_q.steps - 16'd1;
				if (st_q.steps == 16'd1) begin
					set_ev[FLG_TIMEOUT] = 1'b1;
					st_d.timer_run = 1'b0;
					st_d.mode = MODE_STANDBY;
				end
			end else begin
				st_d.presc = st_q.presc - 17'd1;
			end
		end

		unique case (st_q.mode)
			MODE_STANDBY: begin
			end
			MODE_TX: begin
				if (tx_end_i) begin
					st_d.mode = MODE_STANDBY;
					st_d.timer_run = 1'b0;
				end
			end
			MODE_RX: begin
				if (pkt_detect_i) begin
					st_d.timer_run = 1'b0;
					st_d.rx_wr = 8'h00;
				end
				if (rx_done_i) begin
					st_d.rx_len = st_q.rx_wr;
					st_d.rx_first = st_q.rx_base;
					st_d.snr = snr_i;
					// continuous reception never leaves rx on a packet
					if (!st_q.rx_cont) begin
						st_d.mode = MODE_STANDBY;
						st_d.timer_run = 1'b0;
					end
				end
			end
		endcase

		if (tx_byte_req_i) begin
			st_d.tx_byte = mem_q[st_q.tx_rd];
			st_d.tx_rd = st_q.tx_rd + 8'd1;
		end

		if (ferr_valid_i) begin
			// inverted iq mirrors the spectrum, so the estimate flips sign
			st_d.ferr = st_q.iq_inv ? FERR_W'(-ferr_i) : ferr_i;
		end

		if (wr_i) begin
			if (hit(addr_i, OFS_STEP_SIZE)) st_d.step_size = wdata_i;
			if (hit(addr_i, OFS_COUNT_HI)) st_d.count_hi = wdata_i;
			if (hit(addr_i, OFS_COUNT_LO)) st_d.count_lo = wdata_i;
			if (hit(addr_i, OFS_ROUTE0)) st_d.route[0] = wdata_i;
			if (hit(addr_i, OFS_ROUTE1)) st_d.route[1] = wdata_i;
			if (hit(addr_i, OFS_ROUTE2)) st_d.route[2] = wdata_i;
			if (hit(addr_i, OFS_TX_BASE)) st_d.tx_base = wdata_i;
			if (hit(addr_i, OFS_RX_BASE)) st_d.rx_base = wdata_i;
			if (hit(addr_i, OFS_IQ_INV)) st_d.iq_inv = wdata_i[0];
			if (hit(addr_i, OFS_BUF_PTR)) st_d.buf_ptr = wdata_i;
			if (hit(addr_i, OFS_BUF_DATA)) begin
				mem_we = 1'b1;
				st_d.buf_ptr = st_q.buf_ptr + 8'd1;
			end
			if (hit(addr_i, OFS_COMMAND)) begin
				st_d.presc = step_cycles(st_q.step_size) - 17'd1;
				st_d.steps = count;
				st_d.rx_cont = 1'b0;
				st_d.timer_run = 1'b0;
				if (wdata_i == OP_START_TX) begin
					st_d.mode = MODE_TX;
					st_d.tx_rd = st_q.tx_base;
					st_d.timer_run = count != COUNT_SINGLE;
				end else if (wdata_i == OP_START_RX) begin
					st_d.mode = MODE_RX;
					st_d.rx_wr = 8'h00;
					st_d.rx_cont = count == COUNT_CONT;
					st_d.timer_run = count != COUNT_SINGLE && count != COUNT_CONT;
				end else begin
					st_d.mode = MODE_STANDBY;
				end
			end
		end

		// a received byte owns the buffer port; a host write in that cycle is lost
		if (st_q.mode == MODE_RX && rx_byte_valid_i) begin
			mem_we = 1'b1;
			mem_wa = st_q.rx_base + st_q.rx_wr;
			mem_wd = rx_byte_i;
			st_d.rx_wr = st_q.rx_wr + 8'd1;
		end

		// set wins over a clear in the same cycle
		st_d.flags = st_q.flags | set_ev;
		if (wr_i && hit(addr_i, OFS_CLEAR)) begin
			st_d.flags = (st_q.flags & ~wdata_i) | set_ev;
		end

		if (rd_i) begin
			unique case (addr_i)
				OFS_STEP_SIZE: st_d.rdata = st_q.step_size;
				OFS_COUNT_HI: st_d.rdata = st_q.count_hi;
				OFS_COUNT_LO: st_d.rdata = st_q.count_lo;
				OFS_FLAGS: st_d.rdata = st_q.flags;
				OFS_ROUTE0: st_d.rdata = st_q.route[0];
				OFS_ROUTE1: st_d.rdata = st_q.route[1];
				OFS_ROUTE2: st_d.rdata = st_q.route[2];
				OFS_SNR: st_d.rdata = st_q.snr;
				OFS_RX_LEN: st_d.rdata = st_q.rx_len;
				OFS_RX_FIRST: st_d.rdata = st_q.rx_first;
				OFS_MODE: st_d.rdata = {5'h00, st_q.mode};
				OFS_TX_BASE: st_d.rdata = st_q.tx_base;
				OFS_RX_BASE: st_d.rdata = st_q.rx_base;
				OFS_IQ_INV: st_d.rdata = {7'h00, st_q.iq_inv};
				OFS_BUF_PTR: st_d.rdata = st_q.buf_ptr;
				OFS_BUF_DATA: begin
					st_d.rdata = mem_q[st_q.buf_ptr];
					st_d.buf_ptr = st_q.buf_ptr + 8'd1;
				end
				OFS_FERR_HIGH: st_d.rdata = {{4{st_q.ferr[19]}}, st_q.ferr[19:16]};
				OFS_FERR_MID: st_d.rdata = st_q.ferr[15:8];
				OFS_FERR_LOW: st_d.rdata = st_q.ferr[7:0];
				default: st_d.rdata = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.mode <= MODE_STANDBY;
		end else begin
			st_q <= st_d;
		end
	end

	// buffer contents are not reset; software writes before it reads
	always_ff @(posedge sys_clk_i) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	assign rdata_o = st_q.rdata;
	assign tx_byte_o = st_q.tx_byte;
	assign tx_active_o = st_q.mode == MODE_TX;
	assign rx_active_o = st_q.mode == MODE_RX;
	assign standby_o = st_q.mode == MODE_STANDBY;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			dio_o[i] = |(st_q.flags & st_q.route[i]);
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	AST_TX_DONE: assert property (st_q.mode == MODE_TX && tx_end_i && !(wr_i && hit(addr_i, OFS_COMMAND))
		|=> st_q.flags[FLG_TX_DONE] && standby_o && !tx_active_o) else $error("tx end missed");
	AST_TIMEOUT: assert property (st_q.timer_run && st_q.presc == 17'd0 && st_q.steps == 16'd1 && !wr_i
		|=> st_q.flags[FLG_TIMEOUT] && st_q.mode == MODE_STANDBY) else $error("timeout not taken");
	AST_TX_ARM: assert property (wr_i && hit(addr_i, OFS_COMMAND) && wdata_i == OP_START_TX
		|=> st_q.timer_run == (count != 16'h0000) && st_q.steps == count) else $error("tx timer arm wrong");
	AST_CLEAR: assert property (wr_i && hit(addr_i, OFS_CLEAR) && set_ev == 8'h00
		|=> st_q.flags == ($past(st_q.flags) & ~$past(wdata_i))) else $error("clear mask wrong");
	AST_RX_DONE: assert property (st_q.mode == MODE_RX && rx_done_i |=> st_q.flags[FLG_RX_DONE])
		else $error("rx done flag missing");
	AST_PREAMBLE: assert property (st_q.mode == MODE_RX && preamble_i |=> st_q.flags[FLG_PREAMBLE])
		else $error("preamble flag missing");
	AST_CONT_STAYS: assert property (st_q.mode == MODE_RX && st_q.rx_cont && rx_done_i && !wr_i
		|=> rx_active_o && st_q.rx_cont) else $error("continuous rx left");
	AST_SINGLE_NO_TIMER: assert property (wr_i && hit(addr_i, OFS_COMMAND) && wdata_i == OP_START_RX
		&& count == COUNT_SINGLE |=> !st_q.timer_run && !st_q.rx_cont) else $error("single rx armed");
	AST_TIMER_STOP: assert property (st_q.mode == MODE_RX && pkt_detect_i && !wr_i
		|=> !st_q.timer_run) else $error("timer runs after detect");
	AST_FLAG_STICKY: assert property (st_q.flags[FLG_RX_DONE] && !(wr_i && hit(addr_i, OFS_CLEAR))
		|=> st_q.flags[FLG_RX_DONE]) else $error("flag dropped");
	AST_DIO_LOW: assert property (st_q.flags == 8'h00 |-> dio_o == 3'b000) else $error("dio high");
	AST_HDR_FAIL: assert property (st_q.mode == MODE_RX && header_fail_i |=> st_q.flags[FLG_HDR_FAIL])
		else $error("header fail flag missing");
	AST_HDR_OK: assert property (st_q.mode == MODE_RX && header_ok_i |=> st_q.flags[FLG_HDR_OK])
		else $error("header ok flag missing");
	AST_SYNC: assert property (st_q.mode == MODE_RX && sync_i |=> st_q.flags[FLG_SYNC])
		else $error("sync flag missing");
	AST_CRC_FAIL: assert property (st_q.mode == MODE_RX && crc_fail_i |=> st_q.flags[FLG_CRC_FAIL])
		else $error("checksum flag missing");
	// a preamble in standby must not leak into the flags
	AST_IDLE_EVENTS: assert property (standby_o && !st_q.flags[FLG_PREAMBLE] && !wr_i
		|=> !st_q.flags[FLG_PREAMBLE])
		else $error("preamble flag outside rx");
	AST_CONT_ARM: assert property (wr_i && hit(addr_i, OFS_COMMAND) && wdata_i == OP_START_RX
		&& count == COUNT_CONT
		|=> rx_active_o && st_q.rx_cont && !st_q.timer_run)
		else $error("continuous rx not set");
	AST_TIMED_ARM: assert property (wr_i && hit(addr_i, OFS_COMMAND) && wdata_i == OP_START_RX
		&& count != COUNT_SINGLE && count != COUNT_CONT
		|=> rx_active_o && st_q.timer_run && !st_q.rx_cont)
		else $error("rx timer not armed");
	AST_SNR_LATCH: assert property (st_q.mode == MODE_RX && rx_done_i |=> st_q.snr == $past(snr_i))
		else $error("snr not latched");
	AST_RX_STATUS: assert property (st_q.mode == MODE_RX && rx_done_i && !wr_i
		|=> st_q.rx_len == $past(st_q.rx_wr) && st_q.rx_first == st_q.rx_base)
		else $error("rx status wrong");
	AST_FERR_SIGN: assert property (ferr_valid_i
		|=> st_q.ferr == ($past(st_q.iq_inv) ? FERR_W'(-$past(ferr_i)) : $past(ferr_i)))
		else $error("frequency error sign wrong");
	AST_FERR_HIGH: assert property (rd_i && addr_i == OFS_FERR_HIGH
		|=> rdata_o == {{4{$past(st_q.ferr[19])}}, $past(st_q.ferr[19:16])})
		else $error("frequency error high byte wrong");
	AST_BUF_WRITE: assert property (wr_i && hit(addr_i, OFS_BUF_DATA) && !(rx_active_o && rx_byte_valid_i)
		|=> mem_q[$past(st_q.buf_ptr)] == $past(wdata_i))
		else $error("buffer write lost");

	COV_TX_DONE: cover property (st_q.mode == MODE_TX ##1 st_q.flags[FLG_TX_DONE] && standby_o);
	COV_RX_TIMEOUT: cover property (rx_active_o ##1 st_q.flags[FLG_TIMEOUT] && standby_o);
	COV_CONT_TWO: cover property (st_q.rx_cont && rx_done_i ##[1:200] st_q.rx_cont && rx_done_i);
	COV_CLEAR: cover property (st_q.flags != 8'h00 ##1 st_q.flags == 8'h00);
	COV_SINGLE_RX: cover property (rx_active_o && !st_q.rx_cont && !st_q.timer_run
		##1 standby_o && st_q.flags[FLG_RX_DONE]);
endmodule

// file: tb/prts_modem_model.sv
`timescale 1ns/100ps
module prts_modem_model (
	input wire logic clk_i,
	input wire logic [7:0] tx_byte_i,
	output logic tx_end_o,
	output logic tx_req_o,
	output logic preamble_o,
	output logic sync_o,
	output logic header_ok_o,
	output logic header_fail_o,
	output logic crc_fail_o,
	output logic det_o,
	output logic bv_o,
	output logic [7:0] rb_o,
	output logic done_o,
	output logic [7:0] snr_o,
	output logic fv_o,
	output logic [19:0] ferr_o
);
	logic [4:0] ev;
	assign {crc_fail_o, header_fail_o, header_ok_o, sync_o, preamble_o} = ev;
	initial begin
		{ev, tx_end_o, tx_req_o, det_o, bv_o, done_o, fv_o} = '0;
		rb_o = 8'h00;
		snr_o = 8'h00;
		ferr_o = 20'h00000;
	end
	task automatic pulse(input logic [4:0] e);
		@(posedge clk_i) ev <= e;
		@(posedge clk_i) ev <= 5'h00;
	endtask
	task automatic txb(output logic [7:0] b);
		@(posedge clk_i) tx_req_o <= 1'b1;
		@(posedge clk_i) tx_req_o <= 1'b0;
		#1 b = tx_byte_i;
	endtask
	task automatic tx_end();
		@(posedge clk_i) tx_end_o <= 1'b1;
		@(posedge clk_i) tx_end_o <= 1'b0;
	endtask
	// payload bytes 0x30.. in order; idle data line shows inverted value, not the last one
	task automatic pkt(input int n, input int gap, input logic [7:0] s, input logic [19:0] f);
		@(posedge clk_i) det_o <= 1'b1;
		repeat (gap) @(posedge clk_i) det_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i) det_o <= 1'b0;
			bv_o <= 1'b1;
			rb_o <= 8'h30 + 8'(i);
		end
		@(posedge clk_i) {bv_o, det_o, done_o, fv_o} <= 4'b0011;
		rb_o <= ~rb_o;
		snr_o <= s;
		ferr_o <= f;
		@(posedge clk_i) {done_o, fv_o} <= 2'b00;
		snr_o <= ~s;
		ferr_o <= ~f;
	endtask
endmodule

// file: tb/packet_radio_txrx_sequencer_tb.sv
`timescale 1ns/100ps
module packet_radio_txrx_sequencer_tb;
	import prts_pkg::*;
	logic clk, rst, wr, rd, te, tq, pr, sy, ho, hf, cf, dt, bv, dn, fv, ta, ra, sb;
	logic [11:0] addr;
	logic [7:0] wdata, rdata, txb, rb, snr, d, x, m, r2;
	logic [19:0] ferr, f;
	logic [2:0] dio;
	logic [31:0] seed = 32'h4;
	int num_errors = 0, n_tests = 0, n;
	prts_sequencer #(.STEP2_CYC(20), .STEP3_CYC(40)) dut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_end_i(te), .tx_byte_req_i(tq),
		.tx_byte_o(txb), .preamble_i(pr), .sync_i(sy), .header_ok_i(ho), .header_fail_i(hf),
		.pkt_detect_i(dt), .rx_byte_valid_i(bv), .rx_byte_i(rb), .rx_done_i(dn), .crc_fail_i(cf),
		.snr_i(snr), .ferr_valid_i(fv), .ferr_i(ferr), .tx_active_o(ta), .rx_active_o(ra),
		.standby_o(sb), .dio_o(dio));
	prts_modem_model m0 (.clk_i(clk), .tx_byte_i(txb), .tx_end_o(te), .tx_req_o(tq), .preamble_o(pr),
		.sync_o(sy), .header_ok_o(ho), .header_fail_o(hf), .crc_fail_o(cf), .det_o(dt), .bv_o(bv),
		.rb_o(rb), .done_o(dn), .snr_o(snr), .fv_o(fv), .ferr_o(ferr));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [23:0] fe(logic [19:0] v, logic inv);
		logic [19:0] s;
		s = inv ? 20'(-v) : v;
		return {{4{s[19]}}, s};
	endfunction
	function automatic logic [2:0] dexp(logic [7:0] fl);
		return {|(fl & r2), fl[7], fl[1]};
	endfunction
	task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic bw(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk) addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask
	task automatic br(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk) addr <= a;
		rd <= 1'b1;
		@(posedge clk) rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic start(input logic [7:0] op, input logic [7:0] st, input logic [15:0] c);
		bw(OFS_STEP_SIZE, st);
		bw(OFS_COUNT_HI, c[15:8]);
		bw(OFS_COUNT_LO, c[7:0]);
		bw(OFS_COMMAND, op);
	endtask
	// bounded wait; the count shows how long the mode lasted
	task automatic wait_sb(input int mx);
		n = 0;
		while (sb !== 1'b1 && n < mx) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic stop_test();
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end
	initial begin
		{addr, wdata, wr, rd} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		br(OFS_MODE, d);
		chk("mode", d, 8'h01);
		br(12'h920, d);
		chk("unmapped", d, 8'h00);
		// modem events outside their mode are ignored
		m0.pulse(5'h1f);
		m0.tx_end();
		br(OFS_FLAGS, d);
		chk("idle ev", d, 8'h00);
		x = rnd();
		m = rnd();
		bw(OFS_TX_BASE, m);
		bw(OFS_BUF_PTR, m);
		bw(OFS_BUF_DATA, x);
		bw(OFS_BUF_DATA, x + 8'h01);
		start(OP_START_TX, 8'h00, 16'h0000);
		chk("tx act", ta, 1'b1);
		m0.txb(d);
		chk("tx b0", d, x);
		m0.txb(d);
		chk("tx b1", d, x + 8'h01);
		m0.tx_end();
		#1 chk("tx stby", {sb, ta}, 2'b10);
		br(OFS_FLAGS, d);
		chk("tx flag", d, 8'h01);
		m = rnd();
		x = rnd();
		f = 20'({rnd(), rnd(), rnd()});
		bw(OFS_RX_BASE, m);
		start(OP_START_RX, 8'h00, COUNT_SINGLE);
		for (int i = 0; i < 5; i++)
			m0.pulse(5'(1 << i));
		m0.pkt(3, 0, x, f);
		#1 chk("rx stby", {sb, ra}, 2'b10);
		br(OFS_FLAGS, d);
		chk("rx flags", d, 8'h7f);
		br(OFS_SNR, d);
		chk("snr", d, x);
		br(OFS_RX_LEN, d);
		chk("len", d, 8'h03);
		br(OFS_RX_FIRST, d);
		chk("first", d, m);
		bw(OFS_BUF_PTR, m);
		br(OFS_BUF_DATA, d);
		chk("rx byte", d, 8'h30);
		for (int i = 0; i < 3; i++) begin
			br(OFS_FERR_HIGH + 12'(i), d);
			chk("ferr", d, fe(f, 1'b0) >> (16 - 8 * i) & 24'hff);
		end
		r2 = rnd();
		bw(OFS_ROUTE0, 8'h02);
		bw(OFS_ROUTE1, 8'h80);
		bw(OFS_ROUTE2, r2);
		chk("dio", dio, dexp(8'h7f));
		m = rnd() | 8'h02;
		bw(OFS_CLEAR, m);
		br(OFS_FLAGS, d);
		chk("clear", d, 8'h7f & ~m);
		chk("dio clr", dio, dexp(8'h7f & ~m));
		bw(OFS_CLEAR, 8'hff);
		start(OP_START_TX, 8'h03, 16'h0002);
		wait_sb(200);
		chk("tx tmo", n >= 75 && n <= 85, 1'b1);
		br(OFS_FLAGS, d);
		chk("tx tmo flag", d, 8'h80);
		bw(OFS_CLEAR, 8'h80);
		start(OP_START_RX, 8'h02, 16'h0002);
		wait_sb(200);
		chk("rx tmo", n >= 35 && n <= 45, 1'b1);
		br(OFS_FLAGS, d);
		chk("rx tmo flag", d, 8'h80);
		bw(OFS_CLEAR, 8'hff);
		// the two longest step sizes in this bench, one step each
		start(OP_START_TX, 8'h00, 16'h0001);
		wait_sb(500);
		chk("tx tmo s0", 24'(n), 24'(STEP0_CYC));
		start(OP_START_RX, 8'h01, 16'h0001);
		wait_sb(2000);
		chk("rx tmo s1", 24'(n), 24'(STEP1_CYC));
		br(OFS_FLAGS, d);
		chk("tmo flags", d, 8'h80);
		bw(OFS_CLEAR, 8'hff);
		start(OP_START_RX, 8'h02, 16'h0002);
		m0.pkt(2, 60, x, f);
		#1 chk("held rx", sb, 1'b1);
		br(OFS_FLAGS, d);
		chk("no tmo", d, 8'h02);
		bw(OFS_CLEAR, 8'hff);
		start(OP_START_RX, 8'h00, COUNT_CONT);
		m0.pkt(1, 0, x, f);
		bw(OFS_IQ_INV, 8'h01);
		f = 20'({rnd(), rnd(), rnd()});
		m0.pkt(2, 0, x, f);
		repeat (100) @(posedge clk);
		#1 chk("cont", {ra, sb}, 2'b10);
		br(OFS_FLAGS, d);
		chk("cont flag", d, 8'h02);
		br(OFS_FERR_LOW, d);
		chk("ferr inv", d, fe(f, 1'b1) & 24'hff);
		br(OFS_FERR_HIGH, d);
		chk("ferr inv hi", d, fe(f, 1'b1) >> 16);
		bw(OFS_COMMAND, OP_STANDBY);
		chk("stby cmd", {ra, sb}, 2'b01);
		stop_test();
	end
endmodule
